// [snv_map.svh]
`ifndef SNV_MAP_SVH
`define SNV_MAP_SVH

// command encodings
`define SNV_CMD_WRITE_ENABLE_CMD      8'h06
`define SNV_CMD_READ      8'h03
`define SNV_CMD_WRITE     8'h02
// array geometry
`define SNV_ADDR_W        11
`define SNV_DEPTH         2048
`define SNV_ADDR_TOP      11'h7FF
// protection bases
`define SNV_PROT_QTR_BASE 11'h600
`define SNV_PROT_HALF_BASE 11'h400
// serial clock divider: half period is this count plus one system cycles;
// eight cycles leave room for both two-flop synchronisers on the read path
`define SNV_SCK_HALF      8'h07

`endif

// [snv_pkg.sv]
package snv_pkg;
    typedef enum logic [2:0] {
        SNV_IDLE,
        SNV_CMD,
        SNV_ADDR,
        SNV_WDATA,
        SNV_RDATA,
        SNV_DONE
    } snv_state_t;

    typedef enum logic [1:0] {
        SNV_OP_WRITE_ENABLE_CMD,
        SNV_OP_READ,
        SNV_OP_WRITE
    } snv_op_t;
endpackage

// [snv_if.sv]
`timescale 1ns/10ps
interface snv_if;
    logic cs_n;
    logic sck;
    logic mosi;
    logic miso;
    logic miso_oe_n;
    logic hold_n;

    modport dev (
        input  cs_n,
        input  sck,
        input  mosi,
        input  hold_n,
        output miso,
        output miso_oe_n
    );
    modport mst (
        output cs_n,
        output sck,
        output mosi,
        output hold_n,
        input  miso,
        input  miso_oe_n
    );
endinterface

// [snv_dev.sv]
`timescale 1ns/10ps
`include "snv_map.svh"

// Function
// R1 - master sends write-enable before writes
// R2 - two address bytes, low eleven used
// R3 - data stored at consecutive addresses
// R4 - address wraps top to zero
// R5 - byte committed at eighth bit
// R6 - no page limit on writes
// R7 - write data shifted msb first
// R8 - deselect ends write, partial dropped
// R9 - master sends read command first
// R10 - read address low eleven bits used
// R11 - input ignored after read address
// R12 - read shifts msb first, advances
// R13 - deselect ends read, output released
// R14 - hold low suspends, keeps position
// R15 - hold high resumes transfer
// R16 - hold changes only with clock low
// R17 - output high impedance while held
// R18 - protected bytes dropped, address advances
// R19 - command encodings, one per select
// R20 - sample rising, drive falling, msb first
// R21 - completed write clears write-enable latch
// R22 - protect bits choose protected range
module snv_dev (
    // system
    input  wire logic clk,
    input  wire logic rst,
    // link
    snv_if.dev        link,
    // protection setting
    input  wire logic block_protect_hi,
    input  wire logic block_protect_lo,
    // status
    output logic      write_enable_latch,
    output logic      busy
);
    logic [1:0]             cs_s;
    logic [1:0]             sck_s;
    logic [1:0]             si_s;
    logic [1:0]             hold_s;
    logic                   sck_d;
    logic                   held;
    snv_pkg::snv_state_t    state;
    snv_pkg::snv_op_t       op;
    logic [7:0]             shreg;
    logic [2:0]             bitcnt;
    logic                   addr_byte;
    logic [`SNV_ADDR_W-1:0] addr;
    logic [7:0]             rd_byte;
    logic [7:0]             mem [0:`SNV_DEPTH-1];
    logic                   rise;
    logic                   fall;
    logic                   cs_act;
    logic [7:0]             next_byte;

    // protected range check
    function automatic logic is_protected(input logic [`SNV_ADDR_W-1:0] a,
                                          input logic hi, input logic lo);
        case ({hi, lo})
            2'b00:   is_protected = 1'b0;
            2'b01:   is_protected = (a >= `SNV_PROT_QTR_BASE);
            2'b10:   is_protected = (a >= `SNV_PROT_HALF_BASE);
            default: is_protected = 1'b1;
        endcase
    endfunction

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cs_s   <= 2'h3;
            sck_s  <= 2'h0;
            si_s   <= 2'h0;
            hold_s <= 2'h3;
            sck_d  <= 1'b0;
        end else begin
            cs_s   <= {cs_s[0], link.cs_n};
            sck_s  <= {sck_s[0], link.sck};
            si_s   <= {si_s[0], link.mosi};
            hold_s <= {hold_s[0], link.hold_n};
            sck_d  <= sck_s[1];
        end
    end

    assign cs_act    = ~cs_s[1];
    assign next_byte = {shreg[6:0], si_s[1]};
    // R14 R16 - edges ignored while held
    assign rise = cs_act & ~held & sck_s[1] & ~sck_d;
    assign fall = cs_act & ~held & ~sck_s[1] & sck_d;

    // R14 R15 - hold sampled with clock low
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            held <= 1'b0;
        end else if (!cs_act) begin
            held <= 1'b0;
        end else if (!sck_s[1]) begin
            held <= ~hold_s[1];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state     <= snv_pkg::SNV_IDLE;
            op        <= snv_pkg::SNV_OP_WRITE_ENABLE_CMD;
            shreg     <= 8'h00;
            bitcnt    <= 3'h0;
            addr_byte <= 1'b0;
            addr      <= '0;
        end else if (!cs_act) begin
            // R8 R13 - deselect drops partial byte
            state  <= snv_pkg::SNV_IDLE;
            bitcnt <= 3'h0;
        end else if (rise) begin
            // R7 R20 - msb first on rising edge
            shreg  <= next_byte;
            bitcnt <= bitcnt + 3'h1;
            case (state)
                snv_pkg::SNV_IDLE, snv_pkg::SNV_CMD: begin
                    state <= snv_pkg::SNV_CMD;
                    if (bitcnt == 3'h7) begin
                        // R19 - decode one command per select
                        case (next_byte)
                            `SNV_CMD_WRITE_ENABLE_CMD: begin
                                op    <= snv_pkg::SNV_OP_WRITE_ENABLE_CMD;
                                state <= snv_pkg::SNV_DONE;
                            end
                            `SNV_CMD_READ: begin
                                op        <= snv_pkg::SNV_OP_READ;
                                state     <= snv_pkg::SNV_ADDR;
                                addr_byte <= 1'b0;
                            end
                            `SNV_CMD_WRITE: begin
                                op        <= snv_pkg::SNV_OP_WRITE;
                                state     <= snv_pkg::SNV_ADDR;
                                addr_byte <= 1'b0;
                            end
                            default: state <= snv_pkg::SNV_DONE;
                        endcase
                    end
                end
                snv_pkg::SNV_ADDR: begin
                    if (bitcnt == 3'h7) begin
                        addr_byte <= 1'b1;
                        // R2 R10 - keep low eleven bits
                        if (!addr_byte) begin
                            addr[10:8] <= next_byte[2:0];
                        end else begin
                            addr[7:0] <= next_byte;
                            state     <= (op == snv_pkg::SNV_OP_READ) ?
                                         snv_pkg::SNV_RDATA : snv_pkg::SNV_WDATA;
                        end
                    end
                end
                snv_pkg::SNV_WDATA, snv_pkg::SNV_RDATA: begin
                    // R3 R4 R6 R12 - advance and wrap
                    if (bitcnt == 3'h7) begin
                        addr <= addr + 11'h001;
                    end
                end
                default: state <= snv_pkg::SNV_DONE;
            endcase
        end
    end

    // R1 R21 - latch set by command, cleared by write
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            write_enable_latch <= 1'b0;
        end else if (rise && state == snv_pkg::SNV_CMD && bitcnt == 3'h7
                     && next_byte == `SNV_CMD_WRITE_ENABLE_CMD) begin
            write_enable_latch <= 1'b1;
        end else if (!cs_act && state == snv_pkg::SNV_WDATA) begin
            write_enable_latch <= 1'b0;
        end
    end

    // R5 R18 - commit at eighth bit unless protected
    always_ff @(posedge clk) begin
        if (rise && state == snv_pkg::SNV_WDATA && bitcnt == 3'h7
            && write_enable_latch
            && !is_protected(addr, block_protect_hi, block_protect_lo)) begin
            mem[addr] <= next_byte;
        end
    end

    // R11 R12 R20 - load and shift on falling edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_byte <= 8'h00;
        end else if (fall && state == snv_pkg::SNV_RDATA) begin
            if (bitcnt == 3'h0) begin
                rd_byte <= mem[addr];
            end else begin
                rd_byte <= {rd_byte[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            link.miso      <= 1'b0;
            link.miso_oe_n <= 1'b1;
            busy           <= 1'b0;
        end else begin
            busy <= cs_act;
            // R13 R17 - release on deselect or hold
            if (!cs_act || held) begin
                link.miso_oe_n <= 1'b1;
            end else if (fall && state == snv_pkg::SNV_RDATA) begin
                link.miso_oe_n <= 1'b0;
                link.miso      <= (bitcnt == 3'h0) ? mem[addr][7] : rd_byte[6];
            end else if (state == snv_pkg::SNV_RDATA && sck_s[1] == 1'b0 && sck_d) begin
                link.miso_oe_n <= 1'b0;
            end
        end
    end
endmodule

// [snv_mst.sv]
`timescale 1ns/10ps
`include "snv_map.svh"

module snv_mst (
    // system
    input  wire logic        clk,
    input  wire logic        rst,
    // link
    snv_if.mst               link,
    // request: op, address, length in bytes
    input  wire logic        req_valid,
    output logic             req_ready,
    input  snv_pkg::snv_op_t req_op,
    input  wire logic [10:0] req_addr,
    input  wire logic [15:0] req_len,
    // write data stream
    input  wire logic        wr_valid,
    output logic             wr_ready,
    input  wire logic [7:0]  wr_data,
    // read data stream
    output logic             rd_valid,
    input  wire logic        rd_ready,
    output logic [7:0]       rd_data,
    // pause
    input  wire logic        pause
);
    logic [1:0]          miso_s;
    logic [7:0]          div;
    logic [7:0]          sh;
    logic [7:0]          rx;
    logic [2:0]          bitn;
    logic [15:0]         left;
    logic [1:0]          phase;
    snv_pkg::snv_op_t    op;
    logic                run;
    logic                tick;
    logic [7:0]          buf_d [0:1];
    logic [1:0]          buf_n;
    logic                buf_rp;
    logic                buf_wp;
    logic                push;
    logic                stop;

    // R14 R15 R16 - clock parks low while paused or held; hold must be high again first
    assign stop = (pause || buf_n == 2'h2 || !link.hold_n) && !link.sck;
    assign tick = run && !stop && div == `SNV_SCK_HALF;
    // two-entry read buffer; the link pauses while it is full
    assign push = tick && link.sck && bitn == 3'h7 && phase == 2'h3 && op == snv_pkg::SNV_OP_READ;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            miso_s <= 2'h0;
        end else begin
            miso_s <= {miso_s[0], link.miso};
        end
    end

    // R16 - hold changes only while clock low
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            link.hold_n <= 1'b1;
        end else if (!link.sck) begin
            link.hold_n <= ~(pause || buf_n == 2'h2);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div <= 8'h00;
        end else if (!run || stop || div == `SNV_SCK_HALF) begin
            div <= 8'h00;
        end else begin
            div <= div + 8'h01;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            run       <= 1'b0;
            link.cs_n <= 1'b1;
            link.sck  <= 1'b0;
            link.mosi <= 1'b0;
            req_ready <= 1'b1;
            wr_ready  <= 1'b0;
            sh        <= 8'h00;
            rx        <= 8'h00;
            bitn      <= 3'h0;
            left      <= 16'h0000;
            phase     <= 2'h0;
            op        <= snv_pkg::SNV_OP_WRITE_ENABLE_CMD;
        end else if (!run) begin
            wr_ready <= 1'b0;
            if (req_valid && req_ready) begin
                run       <= 1'b1;
                req_ready <= 1'b0;
                link.cs_n <= 1'b0;
                op        <= req_op;
                left      <= req_len;
                phase     <= 2'h0;
                bitn      <= 3'h0;
                // R9 R19 - command is the first byte of the frame
                case (req_op)
                    snv_pkg::SNV_OP_READ:  sh <= `SNV_CMD_READ;
                    snv_pkg::SNV_OP_WRITE: sh <= `SNV_CMD_WRITE;
                    default:               sh <= `SNV_CMD_WRITE_ENABLE_CMD;
                endcase
                link.mosi <= (req_op == snv_pkg::SNV_OP_WRITE_ENABLE_CMD) ? 1'b0 : 1'b0;
            end else begin
                req_ready <= link.cs_n;
                link.cs_n <= 1'b1;
            end
        end else if (tick && !(link.sck == 1'b0 && buf_n == 2'h2)) begin
            link.sck <= ~link.sck;
            if (!link.sck) begin
                rx <= {rx[6:0], miso_s[1]};
            end else begin
                bitn <= bitn + 3'h1;
                if (bitn == 3'h7) begin
                    if (phase != 2'h3) begin
                        phase <= phase + 2'h1;
                    end else begin
                        left <= left - 16'h0001;
                    end
                    if ((op == snv_pkg::SNV_OP_WRITE_ENABLE_CMD) ||
                        (phase == 2'h3 && left == 16'h0001)) begin
                        run <= 1'b0;
                    end else if (phase == 2'h0) begin
                        sh <= {5'h00, req_addr[10:8]};
                    end else if (phase == 2'h1) begin
                        sh <= req_addr[7:0];
                    end else if (op == snv_pkg::SNV_OP_WRITE && wr_valid) begin
                        sh       <= wr_data;
                        wr_ready <= 1'b1;
                    end else begin
                        sh <= 8'h00;
                    end
                end else begin
                    sh <= {sh[6:0], 1'b0};
                end
            end
            link.mosi <= link.sck ? sh[6] : sh[7];
        end else begin
            wr_ready <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            buf_n  <= 2'h0;
            buf_rp <= 1'b0;
            buf_wp <= 1'b0;
        end else begin
            if (push) begin
                // rx already holds all eight bits from the rising edges
                buf_d[buf_wp] <= rx;
                buf_wp        <= ~buf_wp;
            end
            if (rd_valid && rd_ready) begin
                buf_rp <= ~buf_rp;
            end
            buf_n <= buf_n + {1'b0, push} - {1'b0, rd_valid && rd_ready};
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_valid <= 1'b0;
            rd_data  <= 8'h00;
        end else begin
            rd_valid <= (buf_n != 2'h0) && !(rd_valid && rd_ready && buf_n == 2'h1);
            rd_data  <= buf_d[(rd_valid && rd_ready) ? ~buf_rp : buf_rp];
        end
    end
endmodule

// [snv_asserts.sv]
`timescale 1ns/10ps
module snv_asserts (
    // system
    input wire logic clk,
    input wire logic rst,
    // link
    input wire logic cs_n,
    input wire logic sck,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe_n,
    input wire logic hold_n
);
    logic       sck_d;
    logic [5:0] nbits;
    logic [2:0] bitpos;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sck_d <= 1'b0;
        end else begin
            sck_d <= sck;
        end
    end

    // edges seen while paused do not count, matching what the device must ignore
    always_ff @(posedge clk or posedge rst) begin
        if (rst || cs_n) begin
            nbits  <= 6'h00;
            bitpos <= 3'h0;
        end else if (sck && !sck_d && hold_n) begin
            bitpos <= bitpos + 3'h1;
            if (nbits != 6'h3F) begin
                nbits <= nbits + 6'h01;
            end
        end
    end

    sequence s_high_phase;
        sck [*8] ##1 !sck;
    endsequence

    a_release_out: assert property ($rose(cs_n) |-> ##[0:4] miso_oe_n)
        else $error("output still driven after deselect");
    a_idle_quiet: assert property (cs_n [*6] |-> miso_oe_n)
        else $error("output driven while deselected");
    a_hold_hiz: assert property (!hold_n [*6] |-> miso_oe_n)
        else $error("output driven while paused");
    a_cmd_quiet: assert property (!cs_n && nbits < 6'h18 |-> miso_oe_n)
        else $error("output driven before address complete");
    a_miso_fall: assert property (!miso_oe_n && !$past(miso_oe_n) && $changed(miso) |-> !sck)
        else $error("output changed while clock high");
    a_mosi_stable: assert property (sck && sck_d |-> $stable(mosi))
        else $error("input line changed while clock high");
    a_sck_idle: assert property (cs_n |-> !sck)
        else $error("serial clock high outside frame");
    a_hold_sck_low: assert property ($changed(hold_n) |-> !sck)
        else $error("pause changed while clock high");
    a_sck_half: assert property ($rose(sck) |-> s_high_phase)
        else $error("serial clock high phase length wrong");
    a_frame_bytes: assert property ($rose(cs_n) |-> bitpos == 3'h0)
        else $error("frame ended inside a byte");
endmodule

// [tb_serial_nv_memory_access.sv]
`timescale 1ns/10ps
`include "snv_map.svh"
module tb_serial_nv_memory_access;
    logic             clk;
    logic             rst;
    logic             block_protect_hi;
    logic             block_protect_lo;
    logic             write_enable_latch;
    logic             busy;
    logic             req_valid;
    logic             req_ready;
    snv_pkg::snv_op_t req_op;
    logic [10:0]      req_addr;
    logic [15:0]      req_len;
    logic             wr_valid;
    logic             wr_ready;
    logic [7:0]       wr_data;
    logic             rd_valid;
    logic             rd_ready;
    logic [7:0]       rd_data;
    logic             pause;
    logic [7:0]       model [0:2047];
    int               n_errors;
    int               samples_checked;

    snv_if link ();
    snv_dev i_snv_dev (.clk(clk), .rst(rst), .link(link), .block_protect_hi(block_protect_hi),
        .block_protect_lo(block_protect_lo), .write_enable_latch(write_enable_latch), .busy(busy));
    snv_mst i_snv_mst (.clk(clk), .rst(rst), .link(link), .req_valid(req_valid),
        .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr), .req_len(req_len),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid),
        .rd_ready(rd_ready), .rd_data(rd_data), .pause(pause));
    snv_asserts i_snv_asserts (.clk(clk), .rst(rst), .cs_n(link.cs_n), .sck(link.sck),
        .mosi(link.mosi), .miso(link.miso), .miso_oe_n(link.miso_oe_n), .hold_n(link.hold_n));

    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check1(input logic got, input logic exp);
        check8({7'h00, got}, {7'h00, exp});
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    function automatic logic prot(input logic [10:0] a);
        case ({block_protect_hi, block_protect_lo})
            2'b00: prot = 1'b0;
            2'b01: prot = a >= `SNV_PROT_QTR_BASE;
            2'b10: prot = a >= `SNV_PROT_HALF_BASE;
            default: prot = 1'b1;
        endcase
    endfunction

    task automatic send_req(input snv_pkg::snv_op_t op, input logic [10:0] a, input int n);
        req_op = op;
        req_addr = a;
        req_len = 16'(n);
        req_valid = 1'b1;
        do @(posedge clk); while (req_ready !== 1'b1);
        #1;
        req_valid = 1'b0;
    endtask

    // bounded by the watchdog; the output must be released at the end
    task automatic wait_idle();
        repeat (4) @(posedge clk);
        while (!(link.cs_n === 1'b1 && req_ready === 1'b1 && busy === 1'b0)) @(posedge clk);
        repeat (8) @(posedge clk);
        #1;
        check1(link.miso_oe_n, 1'b1);
    endtask

    task automatic mem_write(input logic [10:0] a, input int n, input logic [7:0] s,
                             input logic en);
        logic [10:0] p;
        if (en) begin
            send_req(snv_pkg::SNV_OP_WRITE_ENABLE_CMD, 11'h000, 0);
            wait_idle();
        end
        check1(write_enable_latch, en);
        send_req(snv_pkg::SNV_OP_WRITE, a, n);
        wr_valid = 1'b1;
        for (int i = 0; i < n; i++) begin
            p = a + 11'(i);
            wr_data = s + 8'(i);
            do @(posedge clk); while (wr_ready !== 1'b1);
            #1;
            if (en && !prot(p)) begin
                model[p] = s + 8'(i);
            end
        end
        wr_valid = 1'b0;
        wait_idle();
        check1(write_enable_latch, 1'b0);
    endtask

    task automatic mem_read(input logic [10:0] a, input int n, input int stall);
        send_req(snv_pkg::SNV_OP_READ, a, n);
        for (int i = 0; i < n; i++) begin
            rd_ready = 1'b1;
            do @(posedge clk); while (rd_valid !== 1'b1);
            check8(rd_data, model[a + 11'(i)]);
            #1;
            if (stall > 0) begin
                rd_ready = 1'b0;
                repeat (stall) @(posedge clk);
                #1;
            end
        end
        rd_ready = 1'b0;
        wait_idle();
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        repeat (60000) @(posedge clk);
        n_errors++;
        conclude();
    end

    initial begin
        n_errors = 0;
        samples_checked = 0;
        rst = 1'b1;
        {block_protect_hi, block_protect_lo} = 2'b00;
        {req_valid, wr_valid, rd_ready, pause} = 4'h0;
        req_op = snv_pkg::SNV_OP_READ;
        req_addr = 11'h000;
        req_len = 16'h0000;
        wr_data = 8'h00;
        repeat (12) @(posedge clk);
        #1;
        rst = 1'b0;
        check1(link.cs_n, 1'b1);
        check1(write_enable_latch, 1'b0);
        $display("test reset done");
        mem_write(11'h7FE, 4, 8'hA0, 1'b1);
        mem_read(11'h7FE, 4, 0);
        mem_write(11'h0F0, 36, 8'h31, 1'b1);
        mem_read(11'h0F0, 36, 0);
        $display("test burst and wrap done");
        mem_write(11'h7FE, 2, 8'h5C, 1'b0);
        mem_read(11'h7FE, 2, 0);
        $display("test write without enable done");
        for (int m = 0; m < 4; m++) begin
            {block_protect_hi, block_protect_lo} = 2'(m);
            mem_write(11'h3FF, 2, 8'(8'h40 + 8'(m * 16)), 1'b1);
            mem_write(11'h5FF, 2, 8'(8'h80 + 8'(m * 16)), 1'b1);
            mem_read(11'h3FF, 2, 0);
            mem_read(11'h5FF, 2, 0);
        end
        {block_protect_hi, block_protect_lo} = 2'b00;
        $display("test protect ranges done");
        // slow reader fills the two-entry buffer and forces the link to pause
        mem_read(11'h0F0, 8, 400);
        $display("test stalled read done");
        fork
            mem_read(11'h7FE, 4, 0);
            begin
                // pause lands in the data phase, where the output is driven
                repeat (500) @(posedge clk);
                #1;
                pause = 1'b1;
                repeat (150) @(posedge clk);
                check1(busy, 1'b1);
                check1(link.miso_oe_n, 1'b1);
                #1;
                pause = 1'b0;
            end
        join
        $display("test paused read done");
        conclude();
    end
endmodule
